// >>> verilog/cmo_pkg.sv
// Constants for the compare/pulse-width output block
`default_nettype none
package cmo_pkg;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int          CMO_NUM_MOD      = 2;
	localparam int          CMO_AW           = 8;
	// Register byte addresses
	localparam logic [7:0]  CMO_OFS_CTRL_A   = 8'h00;
	localparam logic [7:0]  CMO_OFS_CTRL_B   = 8'h04;
	localparam logic [7:0]  CMO_OFS_VLO_A    = 8'h08;
	localparam logic [7:0]  CMO_OFS_VHI_A    = 8'h0C;
	localparam logic [7:0]  CMO_OFS_VLO_B    = 8'h10;
	localparam logic [7:0]  CMO_OFS_VHI_B    = 8'h14;
	localparam logic [7:0]  CMO_OFS_WDT      = 8'h18;
	localparam logic [7:0]  CMO_OFS_OVERLAY  = 8'h1C;
	localparam logic [7:0]  CMO_OFS_TSEL     = 8'h20;
	localparam logic [7:0]  CMO_OFS_STATUS   = 8'h24;
	localparam logic [7:0]  CMO_OFS_CLEAR    = 8'h28;
	localparam logic [7:0]  CMO_OFS_ENABLE   = 8'h2C;
	// Field layout of the module control register
	localparam int          CMO_MODE_LSB     = 0;
	localparam int          CMO_DUTY_LSB     = 4;
	localparam logic [7:0]  CMO_CTRL_MASK    = 8'h3F;
	localparam int          CMO_SEL_BIT      = 4;
	localparam logic [7:0]  CMO_OD_MASK      = 8'h1F;
	localparam int          CMO_OD_BIT_A     = 3;
	localparam int          CMO_OD_BIT_B     = 4;
	localparam logic [7:0]  CMO_RST_BYTE     = 8'h00;
	localparam logic [1:0]  CMO_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  CMO_RESP_SLVERR  = 2'h2;
	localparam logic [9:0]  CMO_DUTY_ZERO    = 10'h000;
	// Mode select codes
	typedef enum logic [3:0] {
		CMO_M_OFF     = 4'h0,
		CMO_M_TOGGLE  = 4'h2,
		CMO_M_SET_HI  = 4'h8,
		CMO_M_SET_LO  = 4'h9,
		CMO_M_SOFTIRQ = 4'hA,
		CMO_M_SPECIAL = 4'hB
	} cmo_mode_t;
	localparam logic [1:0]  CMO_PWM_TOP      = 2'h3;
endpackage
`default_nettype wire

// >>> verilog/cmo_compare_output.sv
// Two compare/pulse-width output modules behind an AXI4-Lite slave
`default_nettype none
// What this block does
// - Compare full 16-bit value against selected first or second time base continuously.
// - On match, drive pin high, low, toggle, or leave it on port latch.
// - Set match flag in the same event as the pin action.
// - Software-interrupt code leaves pin untouched, only sets match flag.
// - Interrupt request forwarded only while the match enable bit is set.
// - Writing zero to a control register forces the compare latch low.
// - Pulse-width mode drives the pin with ten-bit duty resolution.
// - Clearing either control register forces its own output latch low.
// - Select bit zero shows the legacy first time base high byte.
// - Select bit one shows the open-drain configuration register instead.
// - Code 0010 toggles the pin on each match and sets the flag.
// - Codes 1000/1001 preset pin low/high, force high/low on match.
// - Code 1011 issues a special event on match and sets the flag.
// - Code 0000 disables the module and clears its duty buffer and output latch; its match flag is kept.
module cmo_compare_output
	import cmo_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [CMO_AW-1:0]    s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	output logic [1:0]                s_axi_bresp,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	input  wire logic [CMO_AW-1:0]    s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	input  wire logic [15:0]          first_time_base,
	input  wire logic [15:0]          second_time_base,
	input  wire logic [7:0]           pwm_timer,
	input  wire logic [1:0]           pwm_fine,
	input  wire logic                 pwm_period_pulse,
	input  wire logic [1:0]           port_g_latch,
	input  wire logic [1:0]           pin_direction_bit,
	output logic [1:0]                module_output_pin,
	output logic [1:0]                module_output_pin_oe,
	output logic [1:0]                special_event,
	output logic                      irq
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]                       ctrl_r [CMO_NUM_MOD];
	logic [15:0]                      value_r [CMO_NUM_MOD];
	logic [9:0]                       duty_buf_r [CMO_NUM_MOD];
	logic [CMO_NUM_MOD-1:0]           eq_prev_r;
	logic [CMO_NUM_MOD-1:0]           out_latch_r;
	logic [CMO_NUM_MOD-1:0]           match_flag_r;
	logic [CMO_NUM_MOD-1:0]           match_irq_enable_r;
	logic [CMO_NUM_MOD-1:0]           tsel_r;
	logic [CMO_NUM_MOD-1:0]           special_r;
	logic [CMO_NUM_MOD-1:0]           pin_r;
	logic [CMO_NUM_MOD-1:0]           oe_r;
	logic [7:0]                       watchdog_ctrl_reg_r;
	logic [7:0]                       open_drain_config_reg_r;
	logic                             aw_hold_r;
	logic                             w_hold_r;
	logic [CMO_AW-1:0]                awaddr_r;
	logic [7:0]                       wdata_r;
	logic                             wstrb0_r;
	logic                             bvalid_r;
	logic [1:0]                       bresp_r;
	logic                             rvalid_r;
	logic [31:0]                      rdata_r;
	logic [1:0]                       rresp_r;
	logic                             wr_fire;
	logic                             wr_en;
	logic                             rd_fire;
	logic [CMO_NUM_MOD-1:0]           ctrl_wr;
	logic [CMO_NUM_MOD-1:0]           match;
	logic [CMO_NUM_MOD-1:0]           od_sel;

	function automatic logic is_compare(input logic [3:0] m);
		return (m == CMO_M_TOGGLE) || (m == CMO_M_SET_HI) || (m == CMO_M_SET_LO) ||
			(m == CMO_M_SOFTIRQ) || (m == CMO_M_SPECIAL);
	endfunction

	function automatic logic is_pwm(input logic [3:0] m);
		return m[3:2] == CMO_PWM_TOP;
	endfunction

	// Pin is steered by the module latch only in modes that own the pin
	function automatic logic owns_pin(input logic [3:0] m);
		return (m == CMO_M_TOGGLE) || (m == CMO_M_SET_HI) || (m == CMO_M_SET_LO) || is_pwm(m);
	endfunction

	function automatic logic addr_known(input logic [CMO_AW-1:0] a);
		return (a == CMO_OFS_CTRL_A) || (a == CMO_OFS_CTRL_B) || (a == CMO_OFS_VLO_A) ||
			(a == CMO_OFS_VHI_A) || (a == CMO_OFS_VLO_B) || (a == CMO_OFS_VHI_B) ||
			(a == CMO_OFS_WDT) || (a == CMO_OFS_OVERLAY) || (a == CMO_OFS_TSEL) ||
			(a == CMO_OFS_STATUS) || (a == CMO_OFS_CLEAR) || (a == CMO_OFS_ENABLE);
	endfunction

	assign od_sel = {open_drain_config_reg_r[CMO_OD_BIT_B], open_drain_config_reg_r[CMO_OD_BIT_A]};

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready  = !w_hold_r && !bvalid_r;
	assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_en         = wr_fire && wstrb0_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_r <= 1'b0;
			wdata_r  <= CMO_RST_BYTE;
			wstrb0_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_r <= 1'b1;
			wdata_r  <= s_axi_wdata[7:0];
			wstrb0_r <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= CMO_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= addr_known(awaddr_r) ? CMO_RESP_OKAY : CMO_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign ctrl_wr[0] = wr_en && (awaddr_r == CMO_OFS_CTRL_A);
	assign ctrl_wr[1] = wr_en && (awaddr_r == CMO_OFS_CTRL_B);

	// Software-owned configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				ctrl_r[i]  <= CMO_RST_BYTE;
				value_r[i] <= '0;
			end
			watchdog_ctrl_reg_r     <= CMO_RST_BYTE;
			open_drain_config_reg_r <= CMO_RST_BYTE;
			tsel_r                  <= '0;
			match_irq_enable_r      <= '0;
		end else if (wr_en) begin
			unique case (awaddr_r)
				CMO_OFS_CTRL_A:  ctrl_r[0] <= wdata_r & CMO_CTRL_MASK;
				CMO_OFS_CTRL_B:  ctrl_r[1] <= wdata_r & CMO_CTRL_MASK;
				CMO_OFS_VLO_A:   value_r[0][7:0] <= wdata_r;
				CMO_OFS_VHI_A:   value_r[0][15:8] <= wdata_r;
				CMO_OFS_VLO_B:   value_r[1][7:0] <= wdata_r;
				CMO_OFS_VHI_B:   value_r[1][15:8] <= wdata_r;
				CMO_OFS_WDT:     watchdog_ctrl_reg_r <= wdata_r;
				CMO_OFS_OVERLAY: begin
					if (watchdog_ctrl_reg_r[CMO_SEL_BIT]) begin
						open_drain_config_reg_r <= wdata_r & CMO_OD_MASK;
					end
				end
				CMO_OFS_TSEL:    tsel_r <= wdata_r[CMO_NUM_MOD-1:0];
				CMO_OFS_ENABLE:  match_irq_enable_r <= wdata_r[CMO_NUM_MOD-1:0];
				default: ;
			endcase
		end
	end

	// Match detection per module
	always_comb begin
		for (int i = 0; i < CMO_NUM_MOD; i++) begin
			// full 16-bit compare on selected base
			// fire on entry into equality only
			match[i] = is_compare(ctrl_r[i][3:0]) && !eq_prev_r[i] &&
				(value_r[i] == (tsel_r[i] ? second_time_base : first_time_base));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eq_prev_r <= '0;
		end else begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				eq_prev_r[i] <= is_compare(ctrl_r[i][3:0]) &&
					(value_r[i] == (tsel_r[i] ? second_time_base : first_time_base));
			end
		end
	end

	// Duty double buffer, reloaded at period end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				duty_buf_r[i] <= CMO_DUTY_ZERO;
			end
		end else begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				if (ctrl_r[i][3:0] == CMO_M_OFF) begin
					duty_buf_r[i] <= CMO_DUTY_ZERO;
				end else if (is_pwm(ctrl_r[i][3:0]) && pwm_period_pulse) begin
					// ten-bit duty from value low and control
					duty_buf_r[i] <= {value_r[i][7:0], ctrl_r[i][CMO_DUTY_LSB +: 2]};
				end
			end
		end
	end

	// Module output latch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_latch_r <= '0;
		end else begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				if (ctrl_wr[i]) begin
					// each control register clears its own latch
					// presets for force-high and force-low codes
					out_latch_r[i] <= (wdata_r[3:0] == CMO_M_SET_LO);
				end else if (is_pwm(ctrl_r[i][3:0])) begin
					if (pwm_period_pulse) begin
						// Zero duty never raises the pin
						out_latch_r[i] <= ({value_r[i][7:0], ctrl_r[i][CMO_DUTY_LSB +: 2]} != CMO_DUTY_ZERO);
					end else if ({pwm_timer, pwm_fine} == duty_buf_r[i]) begin
						out_latch_r[i] <= 1'b0;
					end
				end else if (match[i]) begin
					unique case (ctrl_r[i][3:0])
						CMO_M_TOGGLE: out_latch_r[i] <= !out_latch_r[i];
						CMO_M_SET_HI: out_latch_r[i] <= 1'b1;
						CMO_M_SET_LO: out_latch_r[i] <= 1'b0;
						default:      out_latch_r[i] <= out_latch_r[i];
					endcase
				end
			end
		end
	end

	// Special event pulse for timer reset and conversion start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			special_r <= '0;
		end else begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				special_r[i] <= match[i] && (ctrl_r[i][3:0] == CMO_M_SPECIAL);
			end
		end
	end

	// Sticky match flags; a match beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_flag_r <= '0;
		end else begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				if (match[i]) begin
					match_flag_r[i] <= 1'b1;
				end else if (wr_en && (awaddr_r == CMO_OFS_CLEAR) && wdata_r[i]) begin
					match_flag_r[i] <= 1'b0;
				end
			end
		end
	end

	assign irq = |(match_flag_r & match_irq_enable_r);

	// Pin drive, registered; direction bit clear means output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_r <= '0;
			oe_r  <= '0;
		end else begin
			for (int i = 0; i < CMO_NUM_MOD; i++) begin
				// non-owning modes follow the port latch
				// drive only while direction bit is clear
				if (od_sel[i]) begin
					pin_r[i] <= 1'b0;
					oe_r[i]  <= !pin_direction_bit[i] &&
						!(owns_pin(ctrl_r[i][3:0]) ? out_latch_r[i] : port_g_latch[i]);
				end else begin
					pin_r[i] <= owns_pin(ctrl_r[i][3:0]) ? out_latch_r[i] : port_g_latch[i];
					oe_r[i]  <= !pin_direction_bit[i];
				end
			end
		end
	end

	assign module_output_pin    = pin_r;
	assign module_output_pin_oe = oe_r;
	assign special_event        = special_r;

	// Read channel, one cycle answer
	assign s_axi_arready = !rvalid_r;
	assign rd_fire       = s_axi_arvalid && !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= CMO_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rresp_r  <= addr_known(s_axi_araddr) ? CMO_RESP_OKAY : CMO_RESP_SLVERR;
			rdata_r  <= '0;
			unique case (s_axi_araddr)
				CMO_OFS_CTRL_A:  rdata_r[7:0] <= ctrl_r[0];
				CMO_OFS_CTRL_B:  rdata_r[7:0] <= ctrl_r[1];
				CMO_OFS_VLO_A:   rdata_r[7:0] <= value_r[0][7:0];
				CMO_OFS_VHI_A:   rdata_r[7:0] <= value_r[0][15:8];
				CMO_OFS_VLO_B:   rdata_r[7:0] <= value_r[1][7:0];
				CMO_OFS_VHI_B:   rdata_r[7:0] <= value_r[1][15:8];
				CMO_OFS_WDT:     rdata_r[7:0] <= watchdog_ctrl_reg_r;
				// legacy view when select bit clear
				CMO_OFS_OVERLAY: rdata_r[7:0] <= watchdog_ctrl_reg_r[CMO_SEL_BIT] ?
					open_drain_config_reg_r : first_time_base[15:8];
				CMO_OFS_TSEL:    rdata_r[CMO_NUM_MOD-1:0] <= tsel_r;
				CMO_OFS_STATUS:  rdata_r[CMO_NUM_MOD-1:0] <= match_flag_r;
				CMO_OFS_ENABLE:  rdata_r[CMO_NUM_MOD-1:0] <= match_irq_enable_r;
				default: ;
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> dv/cmo_monitor.sv
// Port-level assertions for the compare output block
`default_nettype none
module cmo_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  pin_direction_bit,
	input wire logic [1:0]  module_output_pin,
	input wire logic [1:0]  module_output_pin_oe,
	input wire logic [1:0]  special_event,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer not held");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_SE_A: assert property (special_event[0] |=> !special_event[0])
		else $error("special event a longer than one cycle");
	AST_SE_B: assert property (special_event[1] |=> !special_event[1])
		else $error("special event b longer than one cycle");
	AST_OE_IN: assert property (pin_direction_bit == 2'b11 |=> module_output_pin_oe == 2'b00)
		else $error("input pin still driven");
	AST_RST_OUT: assert property ($rose(aresetn) |-> module_output_pin == 2'b00 && !irq)
		else $error("outputs not cleared by reset");
	// Main scenarios
	COV_IRQ: cover property ($rose(irq));
	COV_SE: cover property (special_event[1]);
	COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// >>> dv/cmo_pin_load.sv
// Pull-up load on the module output pins
`default_nettype none
module cmo_pin_load (
	input wire logic [1:0] module_output_pin,
	input wire logic [1:0] module_output_pin_oe,
	output logic [1:0]     line_lvl
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pin floats up, never keeps its last level
	assign line_lvl = (module_output_pin & module_output_pin_oe) | ~module_output_pin_oe;
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the compare output block
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("unexpected t=%0t got %0h exp %0h", $time, g, e); end end
module tb
	import cmo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, pwm_period_pulse;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, pwm_timer;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, pwm_fine, port_g_latch, pin_direction_bit;
	logic [1:0]  module_output_pin, module_output_pin_oe, special_event, line_lvl;
	logic [15:0] first_time_base, second_time_base;
	int          err_total = 0, compares = 0, se_cnt = 0;

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;
	// Counted mid-cycle so the count never races the checks
	always @(negedge aclk) if (special_event[1] === 1'b1) se_cnt++;

	cmo_compare_output dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .first_time_base(first_time_base), .second_time_base(second_time_base),
		.pwm_timer(pwm_timer), .pwm_fine(pwm_fine), .pwm_period_pulse(pwm_period_pulse),
		.port_g_latch(port_g_latch), .pin_direction_bit(pin_direction_bit),
		.module_output_pin(module_output_pin), .module_output_pin_oe(module_output_pin_oe),
		.special_event(special_event), .irq(irq));
	cmo_pin_load load (.module_output_pin(module_output_pin), .module_output_pin_oe(module_output_pin_oe),
		.line_lvl(line_lvl));

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic finish_test();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tmo();
		err_total++;
		finish_test();
	endtask
	// Ready held back two cycles so the answer must stand
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			s_axi_bready <= (n > 2) && !(s_axi_bvalid && s_axi_bready);
		end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
		rsp = s_axi_bresp;
		if (n >= 50) tmo();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			s_axi_rready <= (n > 1) && !(s_axi_rvalid && s_axi_rready);
		end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		if (n >= 50) tmo();
	endtask
	// Equality held four cycles, then dropped
	// bases change only on aclk
	// Even hold length exposes a toggle on every equal cycle
	task automatic hit(input logic [15:0] v);
		first_time_base <= v;
		tick(4);
		first_time_base <= 16'h0000;
		tick(2);
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pwm_period_pulse} = '0;
		{s_axi_awaddr, s_axi_araddr, pwm_timer, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{pwm_fine, port_g_latch, pin_direction_bit, first_time_base, second_time_base} = '0;
		s_axi_wstrb = 4'hF;
		aresetn = 1'b0;
		tick(20);
		aresetn <= 1'b1;
		rd(CMO_OFS_CTRL_A, d);
		`CHK(d, 32'h00000000)
		`CHK(rsp, CMO_RESP_OKAY)
		wr(8'h40, 8'h01);
		`CHK(rsp, CMO_RESP_SLVERR)
		rd(8'h40, d);
		`CHK(rsp, CMO_RESP_SLVERR)
		`CHK(d, 32'h00000000)
		wr(CMO_OFS_VLO_A, 8'h34);
		wr(CMO_OFS_VHI_A, 8'h12);
		wr(CMO_OFS_CTRL_A, 8'h08);
		tick(2);
		`CHK(line_lvl[0], 1'b0)
		hit(16'h1234);
		`CHK(module_output_pin[0], 1'b1)
		`CHK(irq, 1'b0)
		rd(CMO_OFS_STATUS, d);
		`CHK(d, 32'h00000001)
		wr(CMO_OFS_ENABLE, 8'h01);
		`CHK(irq, 1'b1)
		wr(CMO_OFS_CLEAR, 8'h01);
		`CHK(irq, 1'b0)
		wr(CMO_OFS_CTRL_A, 8'h09);
		tick(2);
		`CHK(module_output_pin[0], 1'b1)
		hit(16'h1234);
		`CHK(module_output_pin[0], 1'b0)
		wr(CMO_OFS_CTRL_A, 8'h02);
		hit(16'h1234);
		`CHK(module_output_pin[0], 1'b1)
		hit(16'h1234);
		`CHK(module_output_pin[0], 1'b0)
		port_g_latch <= 2'b01;
		wr(CMO_OFS_CTRL_A, 8'h0A);
		wr(CMO_OFS_CLEAR, 8'h03);
		hit(16'h1234);
		`CHK(module_output_pin[0], 1'b1)
		`CHK(irq, 1'b1)
		port_g_latch <= 2'b00;
		wr(CMO_OFS_ENABLE, 8'h00);
		`CHK(irq, 1'b0)
		`CHK(module_output_pin[0], 1'b0)
		wr(CMO_OFS_VLO_A, 8'h02);
		wr(CMO_OFS_CTRL_A, 8'hDC);
		rd(CMO_OFS_CTRL_A, d);
		`CHK(d, 32'h0000001C)
		pwm_period_pulse <= 1'b1;
		tick(1);
		pwm_period_pulse <= 1'b0;
		tick(2);
		`CHK(module_output_pin[0], 1'b1)
		pwm_timer <= 8'h02;
		pwm_fine <= 2'h1;
		tick(3);
		`CHK(module_output_pin[0], 1'b0)
		wr(CMO_OFS_CTRL_A, 8'h00);
		rd(CMO_OFS_CTRL_A, d);
		`CHK(d, 32'h00000000)
		`CHK(module_output_pin[0], port_g_latch[0])
		wr(CMO_OFS_TSEL, 8'h02);
		wr(CMO_OFS_VLO_B, 8'hEF);
		wr(CMO_OFS_VHI_B, 8'hBE);
		wr(CMO_OFS_CTRL_B, 8'h0B);
		first_time_base <= 16'hBEEF;
		tick(5);
		`CHK(se_cnt, 0)
		second_time_base <= 16'hBEEF;
		tick(8);
		`CHK(se_cnt, 1)
		rd(CMO_OFS_STATUS, d);
		`CHK(d[1], 1'b1)
		rd(CMO_OFS_OVERLAY, d);
		`CHK(d, 32'h000000BE)
		wr(CMO_OFS_WDT, 8'h10);
		wr(CMO_OFS_OVERLAY, 8'hFF);
		rd(CMO_OFS_OVERLAY, d);
		`CHK(d, 32'h0000001F)
		wr(CMO_OFS_CTRL_A, 8'h09);
		tick(2);
		`CHK(line_lvl[0], 1'b1)
		wr(CMO_OFS_CTRL_A, 8'h08);
		tick(2);
		`CHK(line_lvl[0], 1'b0)
		pin_direction_bit <= 2'b11;
		tick(2);
		`CHK(module_output_pin_oe, 2'b00)
		finish_test();
	end
endmodule
bind cmo_compare_output cmo_monitor mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .pin_direction_bit(pin_direction_bit), .module_output_pin(module_output_pin),
	.module_output_pin_oe(module_output_pin_oe), .special_event(special_event), .irq(irq));
`default_nettype wire
